/* hdl/psr_pkg.sv */
// Constants, register map and operating-point table for the request unit.
// Assumes a 125 MHz processor clock and a 32-bit register port.
package psr_pkg;

  localparam int CLK_MHZ = 125;
  localparam int ADDR_W  = 8;
  localparam int DATA_W  = 32;
  localparam int CODE_W  = 16;
  localparam int FREQ_W  = 12;
  localparam int IDX_W   = 3;
  localparam int CNT_W   = 16;

  // Register offsets.
  localparam logic [7:0] PSR_OFF_REQ    = 8'h00;
  localparam logic [7:0] PSR_OFF_REPORT = 8'h04;
  localparam logic [7:0] PSR_OFF_MISC   = 8'h08;
  localparam logic [7:0] PSR_OFF_IDENT  = 8'h0c;
  localparam logic [7:0] PSR_OFF_STAT   = 8'h10;

  // Field positions.
  localparam int PSR_MISC_EN_BIT   = 16;
  localparam int PSR_IDENT_CAP_BIT = 7;
  localparam int PSR_STAT_BUSY     = 0;
  localparam int PSR_STAT_PEND     = 1;
  localparam int PSR_STAT_REJ      = 2;

  // Reset values.
  localparam logic [15:0] PSR_RESET_CODE = 16'h0000;
  localparam logic [11:0] PSR_RESET_FREQ = 12'h320;

  // Settling time of one step, in ns.
  localparam int PSR_SETTLE_NS_DEF = 1000;

  typedef enum logic [2:0]
  {
    PSR_IDLE   = 3'b000,
    PSR_LOOKUP = 3'b001,
    PSR_CHECK  = 3'b011,
    PSR_SETTLE = 3'b010
  } psr_state_e;

  typedef struct packed
  {
    logic              valid;
    logic [FREQ_W-1:0] freq_mhz;
  } psr_entry_s;

  // Legal codes have zero upper bits; the low bits select an entry.
  function automatic psr_entry_s psr_entry(input logic [IDX_W-1:0] idx);
    psr_entry_s e;
    e = '{valid: 1'b0, freq_mhz: 12'h000};
    case (idx)
      3'h0: e = '{valid: 1'b1, freq_mhz: PSR_RESET_FREQ};
      3'h1: e = '{valid: 1'b1, freq_mhz: 12'h3e8};
      3'h2: e = '{valid: 1'b1, freq_mhz: 12'h4b0};
      3'h3: e = '{valid: 1'b1, freq_mhz: 12'h640};
      3'h4: e = '{valid: 1'b1, freq_mhz: 12'h7d0};
      3'h5: e = '{valid: 1'b1, freq_mhz: 12'h960};
      default: e = '{valid: 1'b0, freq_mhz: 12'h000};
    endcase
    return e;
  endfunction

endpackage

/* hdl/psr_table.sv */
// Operating-point table with a registered read port.
// Assumes the index is held stable for the cycle after it is presented.
module psr_table
  import psr_pkg::*;
(
  // Clock and reset
  input  wire logic             clk_sys,
  input  wire logic             rst,
  // Read port
  input  wire logic [IDX_W-1:0] rd_idx,
  output psr_entry_s            rd_data
);

  psr_entry_s data_reg;

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      data_reg <= '{valid: 1'b0, freq_mhz: 12'h000};
    else
      data_reg <= psr_entry(rd_idx);
  end

  assign rd_data = data_reg;

endmodule

/* hdl/psr_top.sv */
// Performance-state request unit: request, report and enable registers.
// Assumes a single-cycle register master on the processor clock.
//
// How it works
// - The identification word reads with its capability bit 7 set.
// - Transitions start only while enable bit 16 is set; reset clears it.
// - Writing a 16-bit code to the request register starts a transition.
// - A write during a transition is kept and taken after it ends.
// - Reading the request register returns the last code written.
// - The report register shows the operating point in effect.
// - A fixed table defines the legal codes and their frequencies.
// - The frequency output jumps straight to the target in one step.
module psr_top
  import psr_pkg::*;
#(
  parameter int SETTLE_NS = PSR_SETTLE_NS_DEF
)
(
  // Clock and reset
  input  wire logic              clk_sys,
  input  wire logic              rst,
  // Register port
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [DATA_W-1:0] reg_rdata,
  // Operating point
  output logic      [FREQ_W-1:0] freq_mhz,
  output logic                   transition_busy
);

  localparam int SETTLE_RAW = (SETTLE_NS * CLK_MHZ + 999) / 1000;
  localparam int SETTLE_CYC = (SETTLE_RAW < 1) ? 1 : SETTLE_RAW;
  localparam logic [CNT_W-1:0] SETTLE_LOAD = CNT_W'(SETTLE_CYC - 1);

  psr_state_e        state_reg;
  logic [CODE_W-1:0] req_reg;
  logic [CODE_W-1:0] active_reg;
  logic [CODE_W-1:0] cur_code_reg;
  logic [FREQ_W-1:0] freq_reg;
  logic [CNT_W-1:0]  cnt_reg;
  logic              enable_reg;
  logic              pending_reg;
  logic              rejected_reg;
  logic              busy_reg;
  logic [DATA_W-1:0] rdata_reg;
  psr_entry_s        tbl_data;
  logic              wr_req;
  logic              wr_misc;
  logic              wr_stat;
  logic              take;
  logic              legal;

  assign wr_req  = reg_wr && (reg_addr == PSR_OFF_REQ);
  assign wr_misc = reg_wr && (reg_addr == PSR_OFF_MISC);
  assign wr_stat = reg_wr && (reg_addr == PSR_OFF_STAT);
  assign take    = (state_reg == PSR_IDLE) && enable_reg && pending_reg;
  assign legal   = tbl_data.valid && (active_reg[CODE_W-1:IDX_W] == '0);

  psr_table u_table
  (
    .clk_sys (clk_sys),
    .rst     (rst),
    .rd_idx  (active_reg[IDX_W-1:0]),
    .rd_data (tbl_data)
  );

  // Request and enable registers as software sees them.
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      req_reg    <= PSR_RESET_CODE;
      enable_reg <= 1'b0;
    end
    else
    begin
      if (wr_req)
        req_reg <= reg_wdata[CODE_W-1:0];
      if (wr_misc)
        enable_reg <= reg_wdata[PSR_MISC_EN_BIT];
    end
  end

  // A new write wins over the take in the same cycle, so nothing is lost.
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      pending_reg <= 1'b0;
    else
      pending_reg <= (pending_reg && !take) || wr_req;
  end

  // Rejected codes are flagged; a set in the clearing cycle wins.
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      rejected_reg <= 1'b0;
    else if ((state_reg == PSR_CHECK) && !legal)
      rejected_reg <= 1'b1;
    else if (wr_stat && reg_wdata[PSR_STAT_REJ])
      rejected_reg <= 1'b0;
  end

  // Transition sequencer. A disable lets the step in flight finish.
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      state_reg    <= PSR_IDLE;
      active_reg   <= PSR_RESET_CODE;
      cur_code_reg <= PSR_RESET_CODE;
      freq_reg     <= PSR_RESET_FREQ;
      cnt_reg      <= '0;
      busy_reg     <= 1'b0;
    end
    else
    begin
      case (state_reg)
        PSR_IDLE:
        begin
          if (take)
          begin
            state_reg  <= PSR_LOOKUP;
            active_reg <= req_reg;
            busy_reg   <= 1'b1;
          end
        end
        PSR_LOOKUP:
          state_reg <= PSR_CHECK;
        PSR_CHECK:
        begin
          if (legal)
          begin
            state_reg <= PSR_SETTLE;
            freq_reg  <= tbl_data.freq_mhz;
            cnt_reg   <= SETTLE_LOAD;
          end
          else
          begin
            state_reg <= PSR_IDLE;
            busy_reg  <= 1'b0;
          end
        end
        PSR_SETTLE:
        begin
          if (cnt_reg == '0)
          begin
            state_reg    <= PSR_IDLE;
            cur_code_reg <= active_reg;
            busy_reg     <= 1'b0;
          end
          else
            cnt_reg <= cnt_reg - 1'b1;
        end
        default:
        begin
          state_reg <= PSR_IDLE;
          busy_reg  <= 1'b0;
        end
      endcase
    end
  end

  // Read data stand for exactly the cycle after the strobe.
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      rdata_reg <= '0;
    else if (reg_rd)
    begin
      rdata_reg <= '0;
      case (reg_addr)
        PSR_OFF_REQ:    rdata_reg[CODE_W-1:0] <= req_reg;
        PSR_OFF_REPORT: rdata_reg[CODE_W-1:0] <= cur_code_reg;
        PSR_OFF_MISC:   rdata_reg[PSR_MISC_EN_BIT] <= enable_reg;
        PSR_OFF_IDENT:  rdata_reg[PSR_IDENT_CAP_BIT] <= 1'b1;
        PSR_OFF_STAT:
        begin
          rdata_reg[PSR_STAT_BUSY] <= busy_reg;
          rdata_reg[PSR_STAT_PEND] <= pending_reg;
          rdata_reg[PSR_STAT_REJ]  <= rejected_reg;
        end
        default:        rdata_reg <= '0;
      endcase
    end
    else
      rdata_reg <= '0;
  end

  assign reg_rdata       = rdata_reg;
  assign freq_mhz        = freq_reg;
  assign transition_busy = busy_reg;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  sequence s_req_write;
    reg_wr && (reg_addr == PSR_OFF_REQ);
  endsequence

  sequence s_req_read;
    reg_rd && (reg_addr == PSR_OFF_REQ);
  endsequence

  sequence s_settle_end;
    (state_reg == PSR_SETTLE) && (cnt_reg == '0);
  endsequence

  property p_cap;
    reg_rd && (reg_addr == PSR_OFF_IDENT) |=> reg_rdata[PSR_IDENT_CAP_BIT];
  endproperty
  a_cap: assert property (p_cap)
    else $error("capability bit not reported");

  property p_gate;
    (state_reg == PSR_IDLE) && !enable_reg |=> (state_reg == PSR_IDLE);
  endproperty
  a_gate: assert property (p_gate)
    else $error("transition started while disabled");

  property p_start;
    (state_reg == PSR_IDLE) && enable_reg && pending_reg
      |=> (state_reg == PSR_LOOKUP) ##1 (state_reg == PSR_CHECK);
  endproperty
  a_start: assert property (p_start)
    else $error("request did not start a transition");

  property p_queue;
    s_req_write and (state_reg != PSR_IDLE) |=> pending_reg;
  endproperty
  a_queue: assert property (p_queue)
    else $error("request during transition was lost");

  property p_readback;
    s_req_write ##1 s_req_read |=> (reg_rdata[CODE_W-1:0] ==
      $past(reg_wdata[CODE_W-1:0], 2));
  endproperty
  a_readback: assert property (p_readback)
    else $error("request readback mismatch");

  property p_report;
    reg_rd && (reg_addr == PSR_OFF_REPORT)
      |=> (reg_rdata[CODE_W-1:0] == $past(cur_code_reg));
  endproperty
  a_report: assert property (p_report)
    else $error("report does not show current point");

  property p_illegal;
    (state_reg == PSR_CHECK) && !legal
      |=> (state_reg == PSR_IDLE) && $stable(cur_code_reg) && rejected_reg;
  endproperty
  a_illegal: assert property (p_illegal)
    else $error("illegal code was not rejected");

  property p_step;
    (state_reg == PSR_CHECK) && legal
      |=> (freq_mhz == $past(tbl_data.freq_mhz));
  endproperty
  a_step: assert property (p_step)
    else $error("frequency did not step to target");

  property p_hold;
    (state_reg == PSR_SETTLE) && ($past(state_reg) == PSR_SETTLE)
      |-> $stable(freq_mhz);
  endproperty
  a_hold: assert property (p_hold)
    else $error("frequency swept during settling");

  property p_done;
    s_settle_end |=> (cur_code_reg == $past(active_reg))
      && (state_reg == PSR_IDLE) && !transition_busy;
  endproperty
  a_done: assert property (p_done)
    else $error("report not updated at completion");

endmodule

/* testbench/tb_top.sv */
// Self-checking bench for the performance-state request unit.
// Assumes the unit alone, driven over its register port at 125 MHz.
module tb_top
  import psr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic              clk_sys;
  logic              rst;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata;
  logic              reg_wr;
  logic              reg_rd;
  logic [DATA_W-1:0] reg_rdata;
  logic [FREQ_W-1:0] freq_mhz;
  logic              transition_busy;
  logic [FREQ_W-1:0] freq_prev;
  logic [DATA_W-1:0] rd_val;
  int                error_cnt;
  int                check_count;

  // A short settle time keeps the run brief; two cycles at this clock.
  psr_top #(
    .SETTLE_NS (16)
  ) u_dut (
    .clk_sys         (clk_sys),
    .rst             (rst),
    .reg_addr        (reg_addr),
    .reg_wdata       (reg_wdata),
    .reg_wr          (reg_wr),
    .reg_rd          (reg_rd),
    .reg_rdata       (reg_rdata),
    .freq_mhz        (freq_mhz),
    .transition_busy (transition_busy)
  );

  initial
  begin
    clk_sys = 1'b0;
  end

  always #4 clk_sys = ~clk_sys;

  task automatic end_of_test();
    if (error_cnt == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [DATA_W-1:0] seen,
                     input logic [DATA_W-1:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask

  task automatic reg_write(input logic [ADDR_W-1:0] a,
                           input logic [DATA_W-1:0] d);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
  endtask

  task automatic reg_read(input logic [ADDR_W-1:0] a,
                          output logic [DATA_W-1:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd   <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  task automatic read_chk(input logic [ADDR_W-1:0] a,
                          input logic [DATA_W-1:0] exp);
    logic [DATA_W-1:0] v;
    reg_read(a, v);
    chk(v, exp);
  endtask

  // Waiting on the port outputs, not on status reads, keeps the bus free.
  task automatic wait_op(input logic [FREQ_W-1:0] f);
    int n;
    n = 0;
    while (n < 200 && !(transition_busy === 1'b0 && freq_mhz === f))
    begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    if (n >= 200)
    begin
      error_cnt++;
      $display("unexpected at %0t: transition did not finish", $time);
      end_of_test();
    end
  endtask

  // Every frequency step must land on a table entry, never in between.
  // Sampling on the falling edge keeps clear of the launching edge.
  always @(negedge clk_sys)
  begin
    freq_prev <= freq_mhz;
    if (!rst && freq_mhz !== freq_prev)
      chk(32'(freq_mhz inside {12'h320, 12'h3e8, 12'h4b0, 12'h640,
                               12'h7d0, 12'h960}), 32'h1);
  end

  initial
  begin
    rst       = 1'b1;
    reg_addr  = 8'h00;
    reg_wdata = 32'h0;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    error_cnt   = 0;
    check_count = 0;
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    chk(32'(freq_mhz), 32'h320);
    chk(32'(transition_busy), 32'h0);
    read_chk(PSR_OFF_REQ, 32'h0);
    read_chk(PSR_OFF_REPORT, 32'h0);
    read_chk(PSR_OFF_MISC, 32'h0);
    read_chk(PSR_OFF_IDENT, 32'h80);
    read_chk(8'h44, 32'h0);
    // Disabled: the request is held pending and nothing moves.
    reg_write(PSR_OFF_REQ, 32'habcd0002);
    repeat (10) @(posedge clk_sys);
    chk(32'(transition_busy), 32'h0);
    chk(32'(freq_mhz), 32'h320);
    read_chk(PSR_OFF_STAT, 32'h2);
    read_chk(PSR_OFF_REQ, 32'h2);
    reg_write(PSR_OFF_MISC, 32'h0001_0000);
    wait_op(12'h4b0);
    read_chk(PSR_OFF_REPORT, 32'h2);
    read_chk(PSR_OFF_MISC, 32'h0001_0000);
    // A second write lands while the first step is still in flight.
    reg_write(PSR_OFF_REQ, 32'h3);
    reg_write(PSR_OFF_REQ, 32'h5);
    read_chk(PSR_OFF_STAT, 32'h3);
    read_chk(PSR_OFF_REQ, 32'h5);
    wait_op(12'h960);
    read_chk(PSR_OFF_REPORT, 32'h5);
    read_chk(PSR_OFF_STAT, 32'h0);
    // Codes outside the table are refused and change nothing.
    for (int i = 0; i < 2; i++)
    begin
      reg_write(PSR_OFF_REQ, (i == 0) ? 32'h6 : 32'h100);
      repeat (8) @(posedge clk_sys);
      chk(32'(freq_mhz), 32'h960);
      read_chk(PSR_OFF_REPORT, 32'h5);
      read_chk(PSR_OFF_STAT, 32'h4);
      reg_write(PSR_OFF_STAT, 32'h4);
      read_chk(PSR_OFF_STAT, 32'h0);
    end
    // Read-only places ignore writes; a fresh step back to the start.
    reg_write(PSR_OFF_REPORT, 32'h3);
    reg_write(PSR_OFF_IDENT, 32'h0);
    read_chk(PSR_OFF_IDENT, 32'h80);
    reg_write(PSR_OFF_REQ, 32'h0);
    wait_op(12'h320);
    read_chk(PSR_OFF_REPORT, 32'h0);
    reg_read(PSR_OFF_REQ, rd_val);
    chk(rd_val, 32'h0);
    // A reset in mid-step drops the enable and the step in flight.
    reg_write(PSR_OFF_REQ, 32'h4);
    @(posedge clk_sys);
    rst <= 1'b1;
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    chk(32'(freq_mhz), 32'h320);
    read_chk(PSR_OFF_MISC, 32'h0);
    read_chk(PSR_OFF_REQ, 32'h0);
    read_chk(PSR_OFF_STAT, 32'h0);
    end_of_test();
  end
endmodule
